// *** hw/umd_cfg.svh ***
// Purpose: Address map constants for the unified memory map decoder.
// Assumes: 24-bit byte addresses, 16-bit data.
// Notes: Bounds are inclusive byte addresses.
`ifndef UMD_CFG_SVH
`define UMD_CFG_SVH
`define UMD_AW 24
`define UMD_SEG_LSB 16
`define UMD_PAGE_LSB 14
`define UMD_PROGRAM_SRAM_LO 24'hE0_0000
`define UMD_PROGRAM_SRAM_HI 24'hE0_0FFF
`define UMD_PROGRAM_SRAM_MIR_HI 24'hE7_FFFF
`define UMD_EMULATED_PROGRAM_SRAM_LO 24'hE8_0000
`define UMD_EMULATED_PROGRAM_SRAM_HI 24'hEF_FFFF
`define UMD_PROGRAM_SRAM_MASK 24'h00_0FFF
`define UMD_FIR_LO 24'hFF_FF00
`define UMD_FLASH0_LO 24'hC0_0000
`define UMD_FLASH0_HI 24'hC2_0FFF
`define UMD_FLASH1_LO 24'hC4_0000
`define UMD_FLASH1_HI 24'hC4_7FFF
`define UMD_FLASH_RES_LO 24'hC0_F000
`define UMD_FLASH_RES_HI 24'hC0_FFFF
`define UMD_FLASH_RSV_HI 24'hDF_FFFF
`define UMD_SECT_LSB 12
`define UMD_PROG_LSB 7
`define UMD_LINE_LSB 4
`define UMD_EXT0_HI 24'h00_7FFF
`define UMD_DATA_SRAM_LO 24'h00_C800
`define UMD_DATA_SRAM_HI 24'h00_DFFF
`define UMD_EXTERNAL_FUNCTION_REGS_LO 24'h00_E000
`define UMD_EXTERNAL_FUNCTION_REGS_HI 24'h00_EFFF
`define UMD_EXTENDED_FUNCTION_REGS_LO 24'h00_F000
`define UMD_EXTENDED_FUNCTION_REGS_HI 24'h00_F1FF
`define UMD_DUAL_PORT_RAM_LO 24'h00_F600
`define UMD_DUAL_PORT_RAM_HI 24'h00_FDFF
`define UMD_DUAL_PORT_RAM_BIT_LO 24'h00_FD00
`define UMD_SFR_LO 24'h00_FE00
`define UMD_SFR_HI 24'h00_FFFF
`define UMD_SFR_BIT_LO 24'h00_FF00
`define UMD_EXTENDED_FUNCTION_REGS_BIT_LO 24'h00_F100
`define UMD_EXT1_LO 24'h01_0000
`define UMD_EXT1_HI 24'h1F_FFFF
`define UMD_CAN_LO 24'h20_0000
`define UMD_CAN_HI 24'h20_3FFF
`define UMD_SER_LO 24'h20_4000
`define UMD_SER_HI 24'h20_4FFF
`define UMD_CANA_LO 24'h20_8000
`define UMD_SERA_HI 24'h20_B7FF
`define UMD_EXTIO_LO 24'h21_0000
`define UMD_EXTIO_HI 24'h3F_FFFF
`define UMD_EXTM_LO 24'h40_0000
`define UMD_EXTM_HI 24'hBF_FFFF
`endif

// *** hw/umd_pkg.sv ***
// Purpose: Types for the unified memory map decoder.
// Assumes: Included configuration header gives the map.
// Notes: Target codes are binary and stable.
package umd_pkg;
   typedef enum logic [3:0] {
      UMD_T_NONE = 4'b0000,
      UMD_T_FLASH0 = 4'b0001,
      UMD_T_FLASH1 = 4'b0010,
      UMD_T_PROGRAM_SRAM = 4'b0011,
      UMD_T_EMULATED_PROGRAM_SRAM = 4'b0100,
      UMD_T_DATA_SRAM = 4'b0101,
      UMD_T_DUAL_PORT_RAM = 4'b0110,
      UMD_T_SFR = 4'b0111,
      UMD_T_EXTENDED_FUNCTION_REGS = 4'b1000,
      UMD_T_EXTERNAL_FUNCTION_REGS = 4'b1001,
      UMD_T_PERIPH = 4'b1010,
      UMD_T_EXT = 4'b1011,
      UMD_T_FIR = 4'b1100,
      UMD_T_RSVD = 4'b1101
   } umd_target_e;
   typedef enum logic [1:0] {
      UMD_U_NONE = 2'b00,
      UMD_U_PMU = 2'b01,
      UMD_U_DMU = 2'b10
   } umd_unit_e;
   typedef struct packed {
      logic valid;
      logic fetch;
      logic write;
      logic word;
      logic bit_op;
      logic [23:0] addr;
      logic [15:0] wdata;
   } umd_req_s;
   typedef struct packed {
      logic valid;
      umd_target_e target;
      umd_unit_e unit;
      logic sysbus;
      logic ext_cycle;
      logic no_pipe_opt;
      logic bit_ok;
      logic wr_block;
      logic err;
      logic [23:0] local_addr;
      logic [7:0] segment;
      logic [1:0] page;
      logic [15:0] wdata;
      logic write;
      logic word;
   } umd_route_s;
   typedef struct packed {
      logic valid;
      logic [127:0] line;
      logic [7:0] par;
   } umd_fline_s;
endpackage : umd_pkg

// *** hw/umd_decoder.sv ***
// Purpose: Routes fetch and data accesses of the linear map to targets.
// Assumes: One request per cycle per port, synchronous inputs.
// Notes: Flash lines carry parity per 16-bit group; correction when ECC is chosen.
// What this block does
// - Decode 16 Mbyte space as 256 64K segments.
// - Split each segment into four 16K pages.
// - Accept byte and word reads and writes.
// - Flag bit addressable DUAL_PORT_RAM and register spans.
// - Internal data memories and registers sit in segment 0.
// - Fetches go through program management unit.
// - Data transfers go through data management unit.
// - System bus carries both directions concurrently.
// - Reserved areas in segment 0 and the flash top sector reserved, or external when present; gaps above segment 0 decode as SFR.
// - Program SRAM at E00000, write protectable region.
// - Data SRAM at 00C800 to 00DFFF.
// - Dual-port RAM at 00F600 with register banks.
// - A 4K and a 512 byte word-wide register space.
// - Flash 4K sectors, protectable in flash 0 only, 128 byte programming.
// - Top sector of flash segment 0 reserved when HAS_EXT_BUS is clear, external when it is set.
// - Flash read protection with password unlock.
// - Flash read 128 bits, modules in parallel.
// - Parity detects single errors, blocks use.
// - ECC flips bit 0 of a single failing 16-bit group before delivery.
// - External IO region disables pipeline optimisations.
// - Serial and CAN ranges via peripheral bus.
`timescale 1ns/1ps
`default_nettype none
`include "umd_cfg.svh"
module umd_decoder
   import umd_pkg::*;
#(
   parameter bit HAS_EXT_BUS = 1'b0,
   parameter int PROGRAM_SRAM_PROT_W = 12
)
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Requests from the core.
   input wire umd_req_s i_fetch_req,
   input wire umd_req_s i_data_req,
   // Protection and mode controls.
   input wire logic [PROGRAM_SRAM_PROT_W-1:0] i_program_sram_prot_limit,
   input wire logic i_flash_rd_prot,
   input wire logic i_flash_unlocked,
   input wire logic [39:0] i_flash_sect_wp,
   input wire logic i_parity_en,
   input wire logic i_ecc_en,
   // Flash line returns from the two modules.
   input wire umd_fline_s i_flash0_line,
   input wire umd_fline_s i_flash1_line,
   // Routed requests.
   output umd_route_s o_fetch_route,
   output umd_route_s o_data_route,
   // Delivered flash lines.
   output logic o_flash0_valid,
   output logic [127:0] o_flash0_line,
   output logic o_flash0_err,
   output logic o_flash1_valid,
   output logic [127:0] o_flash1_line,
   output logic o_flash1_err
);
   // -------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------
   // Fixed-priority decode of one address; first match wins.
   function automatic umd_target_e decode(input logic [23:0] a);
      umd_target_e t;
      t = UMD_T_RSVD;
      if (a >= `UMD_FIR_LO) t = UMD_T_FIR;
      else if (a >= `UMD_EMULATED_PROGRAM_SRAM_LO && a <= `UMD_EMULATED_PROGRAM_SRAM_HI)
         t = UMD_T_EMULATED_PROGRAM_SRAM;
      else if (a >= `UMD_PROGRAM_SRAM_LO && a <= `UMD_PROGRAM_SRAM_MIR_HI)
         t = UMD_T_PROGRAM_SRAM;
      else if (a >= `UMD_FLASH_RES_LO && a <= `UMD_FLASH_RES_HI)
         t = UMD_T_RSVD;
      else if (a >= `UMD_FLASH0_LO && a <= `UMD_FLASH0_HI)
         t = UMD_T_FLASH0;
      else if (a >= `UMD_FLASH1_LO && a <= `UMD_FLASH1_HI)
         t = UMD_T_FLASH1;
      else if (a >= `UMD_EXTM_LO && a <= `UMD_EXTM_HI) t = UMD_T_EXT;
      else if (a >= `UMD_EXTIO_LO && a <= `UMD_EXTIO_HI) t = UMD_T_EXT;
      else if (a >= `UMD_CAN_LO && a <= `UMD_SER_HI)
         t = UMD_T_PERIPH;
      else if (a >= `UMD_CANA_LO && a <= `UMD_SERA_HI) t = UMD_T_PERIPH;
      else if (a >= `UMD_EXT1_LO && a <= `UMD_EXT1_HI) t = UMD_T_EXT;
      else if (a >= `UMD_SFR_LO) t = UMD_T_SFR;
      else if (a >= `UMD_DUAL_PORT_RAM_LO && a <= `UMD_DUAL_PORT_RAM_HI)
         t = UMD_T_DUAL_PORT_RAM;
      else if (a >= `UMD_EXTENDED_FUNCTION_REGS_LO && a <= `UMD_EXTENDED_FUNCTION_REGS_HI) t = UMD_T_EXTENDED_FUNCTION_REGS;
      else if (a >= `UMD_EXTERNAL_FUNCTION_REGS_LO && a <= `UMD_EXTERNAL_FUNCTION_REGS_HI) t = UMD_T_EXTERNAL_FUNCTION_REGS;
      else if (a >= `UMD_DATA_SRAM_LO && a <= `UMD_DATA_SRAM_HI)
         t = UMD_T_DATA_SRAM;
      else if (a <= `UMD_EXT0_HI) t = UMD_T_EXT;
      return t;
   endfunction : decode

   // Builds the full route for one request.
   function automatic umd_route_s route(input umd_req_s r,
      input logic [PROGRAM_SRAM_PROT_W-1:0] lim, input logic rdp,
      input logic unl, input logic [39:0] wp);
      umd_route_s o;
      umd_target_e t;
      logic [23:0] off;
      logic [11:0] sect;
      o = '0;
      t = decode(r.addr);
      o.valid = r.valid;
      o.write = r.write;
      o.word = r.word;
      o.wdata = r.wdata;
      o.segment = r.addr[`UMD_AW-1:`UMD_SEG_LSB];
      o.page = r.addr[`UMD_SEG_LSB-1:`UMD_PAGE_LSB];
      o.local_addr = r.addr;
      // Mirrors fold onto the single physical RAM.
      if (t == UMD_T_PROGRAM_SRAM || t == UMD_T_EMULATED_PROGRAM_SRAM)
         o.local_addr = r.addr & `UMD_PROGRAM_SRAM_MASK;
      // Unit ownership: fetch side versus data side.
      case (t)
         UMD_T_FLASH0, UMD_T_FLASH1, UMD_T_PROGRAM_SRAM, UMD_T_EMULATED_PROGRAM_SRAM:
            o.unit = UMD_U_PMU;
         UMD_T_NONE, UMD_T_RSVD: o.unit = UMD_U_NONE;
         default: o.unit = UMD_U_DMU;
      endcase
      // Cross traffic between the units uses the system bus.
      o.sysbus = r.valid && ((r.fetch && o.unit == UMD_U_DMU) ||
         (!r.fetch && o.unit == UMD_U_PMU) || t == UMD_T_PERIPH ||
         t == UMD_T_EXT);
      // Reserved areas go external when a bus exists.
      if (t == UMD_T_RSVD && HAS_EXT_BUS)
      begin
         t = UMD_T_EXT;
         o.unit = UMD_U_DMU;
         o.sysbus = r.valid;
      end
      o.target = t;
      o.ext_cycle = (t == UMD_T_EXT);
      o.no_pipe_opt = r.addr >= `UMD_EXTIO_LO &&
         r.addr <= `UMD_EXTIO_HI;
      // Bit addressing spans in segment 0.
      o.bit_ok = (t == UMD_T_DUAL_PORT_RAM && r.addr >= `UMD_DUAL_PORT_RAM_BIT_LO) ||
         (t == UMD_T_SFR && r.addr >= `UMD_SFR_BIT_LO) ||
         (t == UMD_T_EXTENDED_FUNCTION_REGS && r.addr >= `UMD_EXTENDED_FUNCTION_REGS_BIT_LO);
      // Word registers refuse byte-wide bit ops outside the bit span.
      // Write protection of program SRAM low region and flash 0 sectors.
      off = r.addr & `UMD_PROGRAM_SRAM_MASK;
      // Full-width index so a far sector never aliases onto a low one.
      sect = r.addr[`UMD_AW-1:`UMD_SECT_LSB] -
         12'(`UMD_FLASH0_LO >> `UMD_SECT_LSB);
      o.wr_block = 1'b0;
      if (r.write && (t == UMD_T_PROGRAM_SRAM || t == UMD_T_EMULATED_PROGRAM_SRAM) &&
         off[PROGRAM_SRAM_PROT_W-1:0] < lim)
         o.wr_block = 1'b1;
      if (r.write && (t == UMD_T_FLASH0 || t == UMD_T_FLASH1) &&
         sect < 12'd40 && wp[sect[5:0]])
         o.wr_block = 1'b1;
      // Read protection until the password sequence has unlocked.
      o.err = r.valid && (t == UMD_T_RSVD || o.wr_block ||
         (r.bit_op && !o.bit_ok) ||
         (!r.write && !r.fetch && rdp && !unl &&
         (t == UMD_T_FLASH0 || t == UMD_T_FLASH1)));
      if (o.err)
         o.valid = 1'b0;
      return o;
   endfunction : route

   // -------------------------------------------------------------
   // Registered routing, fetch and data ports in parallel
   // -------------------------------------------------------------
   umd_route_s next_fetch_route;
   umd_route_s next_data_route;
   always_comb
   begin
      next_fetch_route = route(i_fetch_req, i_program_sram_prot_limit,
         i_flash_rd_prot, i_flash_unlocked, i_flash_sect_wp);
      next_data_route = route(i_data_req, i_program_sram_prot_limit,
         i_flash_rd_prot, i_flash_unlocked, i_flash_sect_wp);
   end

   // Both ports register every cycle; no port stalls the other.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_fetch_route <= '0;
         o_data_route <= '0;
      end
      else
      begin
         o_fetch_route <= next_fetch_route;
         o_data_route <= next_data_route;
      end
   end

   // -------------------------------------------------------------
   // Flash line protection
   // -------------------------------------------------------------
   // 16-bit group parity check; with ECC a single bad group parity is taken
   // as a flip of the lowest bit of that failing group.
   function automatic logic [8:0] chk(input umd_fline_s l,
      input logic pen, input logic een);
      logic [7:0] bad;
      logic [8:0] res;
      bad = '0;
      res = '0;
      for (int i = 0; i < 8; i++)
         bad[i] = ^{l.line[i*16 +: 16], l.par[i]};
      if (een)
         res[8] = $countones(bad) > 1;
      else if (pen)
         res[8] = |bad;
      res[7:0] = bad;
      return res;
   endfunction : chk

   umd_fline_s fl [2];
   logic [127:0] next_line [2];
   logic [1:0] next_err;
   always_comb
   begin
      fl[0] = i_flash0_line;
      fl[1] = i_flash1_line;
      for (int m = 0; m < 2; m++)
      begin
         logic [8:0] c;
         c = chk(fl[m], i_parity_en, i_ecc_en);
         next_line[m] = fl[m].line;
         next_err[m] = c[8];
         // Correct the lowest bit of the single failing group.
         if (i_ecc_en && $countones(c[7:0]) == 1)
            for (int g = 0; g < 8; g++)
               if (c[g])
                  next_line[m][g*16] = ~fl[m].line[g*16];
         if (next_err[m])
            next_line[m] = '0;
      end
   end

   // Each module returns its 128-bit line independently.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_flash0_valid <= 1'b0;
         o_flash1_valid <= 1'b0;
         o_flash0_line <= '0;
         o_flash1_line <= '0;
         o_flash0_err <= 1'b0;
         o_flash1_err <= 1'b0;
      end
      else
      begin
         o_flash0_valid <= i_flash0_line.valid;
         o_flash1_valid <= i_flash1_line.valid;
         o_flash0_line <= next_line[0];
         o_flash1_line <= next_line[1];
         o_flash0_err <= i_flash0_line.valid && next_err[0];
         o_flash1_err <= i_flash1_line.valid && next_err[1];
      end
   end
endmodule : umd_decoder
`default_nettype wire

// *** bench/umd_flash_model.sv ***
// Purpose: Flash module stand-in that hands lines to the decoder.
// Assumes: One line per send pulse.
// Notes: Faults are added after the parity is formed.
`timescale 1ns/1ps
`default_nettype none
module umd_flash_model
   import umd_pkg::*;
(
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_sys_rst,
   // Line to send and fault mask.
   input wire logic i_send,
   input wire logic [127:0] i_line,
   input wire logic [127:0] i_flip,
   // Line to the decoder.
   output umd_fline_s o_line
);
   logic [7:0] par;
   // Even parity over each 16-bit group.
   always_comb
      for (int g = 0; g < 8; g++)
         par[g] = ^i_line[16*g +: 16];
   // Whole 128-bit line; an idle line toggles, showing the stale data again every second idle cycle.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         o_line <= '0;
      else
      begin
         o_line.valid <= i_send;
         o_line.line <= i_send ? (i_line ^ i_flip) : ~o_line.line;
         o_line.par <= par;
      end
   end
endmodule : umd_flash_model
`default_nettype wire

// *** bench/umd_properties.sv ***
// Purpose: Port checks for the memory map decoder.
// Assumes: Routes appear one cycle after the request.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
`default_nettype none
`include "umd_cfg.svh"
module umd_properties
   import umd_pkg::*;
#(
   parameter bit HAS_EXT_BUS = 1'b0,
   parameter int PROGRAM_SRAM_PROT_W = 12
)
(
   // Watched ports.
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire umd_req_s i_fetch_req,
   input wire umd_req_s i_data_req,
   input wire umd_fline_s i_flash0_line,
   input wire logic i_parity_en,
   input wire logic i_ecc_en,
   input wire umd_route_s o_fetch_route,
   input wire umd_route_s o_data_route,
   input wire logic o_flash0_valid,
   input wire logic [127:0] o_flash0_line
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic dv;
   logic [23:0] a;
   // Plain data reads and the address they carry.
   assign dv = i_data_req.valid && !i_data_req.bit_op && !i_data_req.write;
   assign a = i_data_req.addr;
   function automatic bit inr(input logic [23:0] x, input logic [23:0] lo,
                              input logic [23:0] hi);
      return x >= lo && x <= hi;
   endfunction : inr
   property p_data_sram;
      dv && inr(a, `UMD_DATA_SRAM_LO, `UMD_DATA_SRAM_HI) |=> o_data_route.valid
         && o_data_route.target == UMD_T_DATA_SRAM
         && o_data_route.unit == UMD_U_DMU;
   endproperty
   a_data_sram: assert property (p_data_sram) else $error("data sram route");
   property p_seg;
      o_data_route.valid |-> o_data_route.segment == $past(a[23:16])
         && o_data_route.page == $past(a[15:14]);
   endproperty
   a_seg: assert property (p_seg) else $error("segment or page");
   property p_fetch;
      o_fetch_route.valid |-> o_fetch_route.unit == UMD_U_PMU
         || o_fetch_route.sysbus;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch unit");
   property p_rsvd;
      !HAS_EXT_BUS && dv && inr(a, 24'h00_8000, 24'h00_C7FF)
         |=> o_data_route.err && !o_data_route.valid;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved access");
   property p_extio;
      i_data_req.valid && inr(a, `UMD_EXTIO_LO, `UMD_EXTIO_HI)
         |=> o_data_route.no_pipe_opt;
   endproperty
   a_extio: assert property (p_extio) else $error("io region");
   property p_periph;
      dv && inr(a, `UMD_CAN_LO, `UMD_SER_HI)
         |=> o_data_route.target == UMD_T_PERIPH;
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral bus");
   property p_fres;
      i_data_req.valid && inr(a, `UMD_FLASH_RES_LO, `UMD_FLASH_RES_HI)
         |=> o_data_route.err ##1 1'b1;
   endproperty
   a_fres: assert property (p_fres) else $error("flash internal sector");
   property p_bit;
      i_data_req.valid && i_data_req.bit_op && !i_data_req.write
         && inr(a, `UMD_DUAL_PORT_RAM_BIT_LO, `UMD_DUAL_PORT_RAM_HI)
         |=> o_data_route.bit_ok && o_data_route.target == UMD_T_DUAL_PORT_RAM;
   endproperty
   a_bit: assert property (p_bit) else $error("bit span");
   property p_flash;
      i_flash0_line.valid && !i_parity_en && !i_ecc_en
         |=> o_flash0_valid && o_flash0_line == $past(i_flash0_line.line);
   endproperty
   a_flash: assert property (p_flash) else $error("flash line");
   c_data_sram: cover property (o_data_route.target == UMD_T_DATA_SRAM);
   c_err: cover property (o_data_route.err);
   c_flash: cover property (o_flash0_valid);
endmodule : umd_properties
bind umd_decoder umd_properties #(
   .HAS_EXT_BUS(HAS_EXT_BUS),
   .PROGRAM_SRAM_PROT_W(PROGRAM_SRAM_PROT_W)
) u_props (.*);
`default_nettype wire

// *** bench/umd_decoder_tb.sv ***
// Purpose: Self-checking bench for the memory map decoder.
// Assumes: Flash models stand in for the two flash modules.
// Notes: Table rows cover plain routes; special cases follow.
`timescale 1ns/1ps
`default_nettype none
module umd_decoder_tb;
   import umd_pkg::*;
   typedef struct {logic [23:0] a; umd_target_e t; logic e;} umd_row_s;
   umd_row_s rows [16] = '{
      '{24'h00_C800, UMD_T_DATA_SRAM, 0}, '{24'h00_DFFF, UMD_T_DATA_SRAM, 0},
      '{24'h00_F600, UMD_T_DUAL_PORT_RAM, 0}, '{24'h00_FDFF, UMD_T_DUAL_PORT_RAM, 0},
      '{24'h00_FE00, UMD_T_SFR, 0}, '{24'h00_F000, UMD_T_EXTENDED_FUNCTION_REGS, 0},
      '{24'h00_E000, UMD_T_EXTERNAL_FUNCTION_REGS, 0}, '{24'h20_0000, UMD_T_PERIPH, 0},
      '{24'h20_4FFF, UMD_T_PERIPH, 0}, '{24'h21_0000, UMD_T_EXT, 0},
      '{24'h40_0000, UMD_T_EXT, 0}, '{24'hE0_0000, UMD_T_PROGRAM_SRAM, 0},
      '{24'hC4_0000, UMD_T_FLASH1, 0}, '{24'hFF_FF00, UMD_T_FIR, 0},
      '{24'h00_8000, UMD_T_RSVD, 1}, '{24'hC0_F000, UMD_T_RSVD, 1}};
   logic i_clock = 0;
   logic i_sys_rst = 1;
   umd_req_s fq = '0;
   umd_req_s dq = '0;
   logic [11:0] lim = '0;
   logic rdp = 0;
   logic unl = 0;
   logic [39:0] wp = '0;
   logic pen = 0;
   logic een = 0;
   logic s0 = 0;
   logic [127:0] l0 = {8{16'hA5C3}};
   logic [127:0] l1 = {8{16'h3C5A}};
   logic [127:0] x0 = '0;
   umd_fline_s f0, f1;
   umd_route_s fr, dr;
   logic v0, v1, e0, e1;
   logic [127:0] ol0, ol1;
   int n_mismatch = 0;
   int cmp_count = 0;
   // Clock and models.
   always #12.5 i_clock = ~i_clock;
   umd_flash_model fm0 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_send(s0), .i_line(l0), .i_flip(x0), .o_line(f0));
   umd_flash_model fm1 (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_send(s0), .i_line(l1), .i_flip(128'h0), .o_line(f1));
   umd_decoder uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_fetch_req(fq), .i_data_req(dq), .i_program_sram_prot_limit(lim),
      .i_flash_rd_prot(rdp), .i_flash_unlocked(unl), .i_flash_sect_wp(wp),
      .i_parity_en(pen), .i_ecc_en(een), .i_flash0_line(f0),
      .i_flash1_line(f1), .o_fetch_route(fr), .o_data_route(dr),
      .o_flash0_valid(v0), .o_flash0_line(ol0), .o_flash0_err(e0),
      .o_flash1_valid(v1), .o_flash1_line(ol1), .o_flash1_err(e1));
   function automatic umd_req_s mk(input logic [23:0] a, input logic w,
                                   input logic b, input logic f);
      return '{1'b1, f, w, 1'b1, b, a, 16'h0000};
   endfunction : mk
   task automatic chk_b(input string n, input logic e, input logic s);
      cmp_count++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk_b
   task automatic chk_t(input string n, input umd_target_e e,
                        input umd_target_e s);
      chk_b(n, e === s, 1'b1);
   endtask : chk_t
   task automatic chk_l(input string n, input logic [127:0] e,
                        input logic [127:0] s);
      chk_b(n, e === s, 1'b1);
   endtask : chk_l
   // One request per port, route looked at one cycle later.
   task automatic go(input umd_req_s d, input umd_req_s f);
      dq = d;
      fq = f;
      @(posedge i_clock);
      #1;
   endtask : go
   task automatic fl(input logic p, input logic e, input logic [127:0] x,
                     input logic ee);
      pen = p;
      een = e;
      x0 = x;
      s0 = 1;
      @(posedge i_clock);
      #1 s0 = 0;
      @(posedge i_clock);
      #1 chk_b("flash err", ee, e0);
      if (!ee)
         chk_l("flash line", l0, ol0);
      else
         chk_l("flash zero", 128'h0, ol0);
      chk_b("flash0 valid", 1'b1, v0);
      chk_b("flash1 err", 1'b0, e1);
      chk_b("flash1 valid", 1'b1, v1);
      chk_l("flash1 line", l1, ol1);
   endtask : fl
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   // Watchdog.
   initial
   begin
      #(2000 * 25);
      n_mismatch++;
      complete_run();
   end
   // Reset, table loop, then the awkward cases.
   initial
   begin
      repeat (6) @(posedge i_clock);
      #1 i_sys_rst = 0;
      chk_b("reset valid", 1'b0, dr.valid);
      foreach (rows[i])
      begin
         go(mk(rows[i].a, 1'b0, 1'b0, 1'b0), mk(rows[i].a, 0, 0, 1));
         chk_b("err", rows[i].e, dr.err);
         chk_b("valid", !rows[i].e, dr.valid);
         if (!rows[i].e)
            chk_t("target", rows[i].t, dr.target);
      end
      lim = 12'h100;
      go(mk(24'hE0_0010, 1, 0, 0), '0);
      chk_b("program_sram protect", 1'b1, dr.err);
      go(mk(24'hE0_0200, 1, 0, 0), '0);
      chk_b("program_sram write", 1'b0, dr.err);
      go(mk(24'hE0_1234, 0, 0, 0), '0);
      chk_l("mirror", 24'h00_0234, dr.local_addr);
      wp = 40'h1;
      go(mk(24'hC0_0000, 1, 0, 0), '0);
      chk_b("sector protect", 1'b1, dr.err);
      go(mk(24'hC0_1000, 1, 0, 0), '0);
      chk_b("sector open", 1'b0, dr.err);
      go(mk(24'h00_F600, 0, 1, 0), '0);
      chk_b("bit outside", 1'b1, dr.err);
      go(mk(24'h00_FD00, 0, 1, 0), '0);
      chk_b("bit inside", 1'b1, dr.bit_ok);
      go(mk(24'h00_FEF0, 1, 0, 0), '0);
      chk_b("sfr zero write", 1'b0, dr.err);
      chk_b("sfr zero data", 1'b1, dr.wdata === 16'h0000);
      rdp = 1;
      go(mk(24'hC0_0000, 0, 0, 0), mk(24'hC0_0000, 0, 0, 1));
      chk_b("locked read", 1'b1, dr.err);
      chk_b("fetch beside", 1'b1, fr.valid);
      unl = 1;
      go(mk(24'hC0_0000, 0, 0, 0), '0);
      chk_b("unlocked read", 1'b0, dr.err);
      fl(1, 0, 128'h0, 0);
      fl(1, 0, 128'h20, 1);
      fl(0, 1, 128'h1_0000_0000, 0);
      fl(0, 1, 128'h1_0001, 1);
      fl(0, 0, 128'h0, 0);
      complete_run();
   end
endmodule : umd_decoder_tb
`default_nettype wire
